// [logic/hgg_regs.sv]
// Purpose: Host runtime registers for pin groups G, H and I.
// Assumes: One host byte access per request, answered next cycle.
// Notes: The supply-valid input is synchronised before use.
`timescale 1ns/10ps
module hgg_regs (
  input wire logic i_mclk, // Bus clock, 25 MHz.
  input wire logic i_reset_n, // Host reset, active low.
  input hgg_pkg::hgg_req_t i_req, // Host I/O request, one-cycle strobes.
  input wire logic i_activate, // Block decode enable.
  input wire logic [15:0] i_base, // Block base address.
  input wire logic [2:0] i_host_source_select, // Per-group host select.
  input wire logic i_pass_through_en, // Group G to group H routing.
  input wire logic i_standby_supply_valid, // Supply good, asynchronous.
  input wire logic [23:0] i_mcu_dir, // Controller directions I,H,G.
  input wire logic [23:0] i_mcu_val, // Controller values I,H,G.
  input wire logic [23:0] i_pin, // Pin levels I,H,G.
  output logic [23:0] o_pin_out, // Pin drive values I,H,G.
  output logic [23:0] o_pin_oe, // Pin enables, high drives.
  output logic [7:0] o_rdata, // Read data.
  output logic o_ack // Access complete pulse.
);

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic [7:0] dir_g_q, drv_g_q, dir_h_q, drv_h_q, dir_i_q, drv_i_q;
  logic [7:0] rdata_q;
  logic ack_q;
  logic pg_meta_q, pg_q;
  wire [11:0] base_blk = i_base[15:hgg_pkg::BASE_ALIGN_BITS];
  wire hit = i_activate && (i_req.addr[15:4] == base_blk);
  wire [3:0] ofs = i_req.addr[3:0];
  wire wr_en = hit && i_req.wr;
  wire rd_en = hit && i_req.rd;
  wire [7:0] lvl_g, lvl_h, lvl_i;

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  // Writable registers; input registers have no storage so writes drop.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dir_g_q <= hgg_pkg::RST_REG;
      drv_g_q <= hgg_pkg::RST_REG;
      dir_h_q <= hgg_pkg::RST_REG;
      drv_h_q <= hgg_pkg::RST_REG;
      dir_i_q <= hgg_pkg::RST_REG;
      drv_i_q <= hgg_pkg::RST_REG;
    end else if (wr_en) begin
      case (ofs)
        hgg_pkg::OFS_DIR_G: dir_g_q <= i_req.wdata;
        hgg_pkg::OFS_DRV_G: drv_g_q <= i_req.wdata;
        hgg_pkg::OFS_DIR_H: dir_h_q <= i_req.wdata;
        hgg_pkg::OFS_DRV_H: drv_h_q <= i_req.wdata;
        hgg_pkg::OFS_DIR_I: dir_i_q <= i_req.wdata;
        hgg_pkg::OFS_DRV_I: drv_i_q <= i_req.wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read mux and answer
  // ----------------------------------------------------------------------
  logic [7:0] rmux;
  // Select read data; unmapped offsets read zero.
  always_comb begin
    case (ofs)
      hgg_pkg::OFS_DIR_G: rmux = dir_g_q;
      hgg_pkg::OFS_LVL_G: rmux = lvl_g;
      hgg_pkg::OFS_DRV_G: rmux = drv_g_q;
      hgg_pkg::OFS_DIR_H: rmux = dir_h_q;
      hgg_pkg::OFS_LVL_H: rmux = lvl_h;
      hgg_pkg::OFS_DRV_H: rmux = drv_h_q;
      hgg_pkg::OFS_DIR_I: rmux = dir_i_q;
      hgg_pkg::OFS_LVL_I: rmux = lvl_i;
      hgg_pkg::OFS_DRV_I: rmux = drv_i_q;
      default: rmux = hgg_pkg::RST_RDATA;
    endcase
  end

  // Answer every decoded access one cycle later.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_q <= hgg_pkg::RST_RDATA;
      ack_q <= 1'b0;
      pg_meta_q <= 1'b0;
      pg_q <= 1'b0;
    end else begin
      rdata_q <= rd_en ? rmux : rdata_q;
      ack_q <= rd_en || wr_en;
      pg_meta_q <= i_standby_supply_valid;
      pg_q <= pg_meta_q;
    end
  end
  assign o_rdata = rdata_q;
  assign o_ack = ack_q;

  // ----------------------------------------------------------------------
  // Pin groups
  // ----------------------------------------------------------------------
  hgg_pkg::hgg_pins_t pins_g, pins_h, pins_i;
  // Pass-through replaces the group H host values with group G levels.
  wire [7:0] h_val = i_pass_through_en ? lvl_g : drv_h_q;

  hgg_group u_grp_g (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_host_sel(i_host_source_select[hgg_pkg::SEL_G]), .i_supply_ok(pg_q),
    .i_host_dir(dir_g_q), .i_host_val(drv_g_q),
    .i_mcu_dir(i_mcu_dir[7:0]), .i_mcu_val(i_mcu_val[7:0]),
    .i_pin(i_pin[7:0]), .o_pins(pins_g), .o_level(lvl_g)
  );
  hgg_group u_grp_h (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_host_sel(i_host_source_select[hgg_pkg::SEL_H]), .i_supply_ok(pg_q),
    .i_host_dir(dir_h_q), .i_host_val(h_val),
    .i_mcu_dir(i_mcu_dir[15:8]), .i_mcu_val(i_mcu_val[15:8]),
    .i_pin(i_pin[15:8]), .o_pins(pins_h), .o_level(lvl_h)
  );
  hgg_group u_grp_i (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_host_sel(i_host_source_select[hgg_pkg::SEL_I]), .i_supply_ok(pg_q),
    .i_host_dir(dir_i_q), .i_host_val(drv_i_q),
    .i_mcu_dir(i_mcu_dir[23:16]), .i_mcu_val(i_mcu_val[23:16]),
    .i_pin(i_pin[23:16]), .o_pins(pins_i), .o_level(lvl_i)
  );

  assign o_pin_out = {pins_i.dout, pins_h.dout, pins_g.dout};
  assign o_pin_oe = {pins_i.oe, pins_h.oe, pins_g.oe};

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_ack_timing: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (rd_en || wr_en) |=> o_ack) else $error("Access not acknowledged next cycle.");
  chk_nodecode_off: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !i_activate |=> !o_ack) else $error("Acknowledge while not activated.");
  chk_dir_g_write: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (wr_en && ofs == hgg_pkg::OFS_DIR_G) |=> dir_g_q == $past(i_req.wdata))
    else $error("Group G direction not written.");

  // A host write to the group G drive value while the host owns group G.
  sequence s_drv_g_write;
    wr_en && (ofs == hgg_pkg::OFS_DRV_G) && i_host_source_select[hgg_pkg::SEL_G];
  endsequence

  // The register takes the byte one edge later and the pin flop one edge after that.
  sequence s_drv_g_follow;
    (drv_g_q == $past(i_req.wdata)) ##1 (o_pin_out[7:0] == $past(i_req.wdata, 2));
  endsequence

  chk_drv_g_pin: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_drv_g_write |=> s_drv_g_follow)
    else $error("Group G drive lag wrong.");
  chk_level_g_read: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (rd_en && ofs == hgg_pkg::OFS_LVL_G) |=> o_rdata == $past(lvl_g))
    else $error("Group G level read wrong.");
  chk_level_i_read: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (rd_en && ofs == hgg_pkg::OFS_LVL_I) |=> o_rdata == $past(lvl_i))
    else $error("Group I level read wrong.");
  chk_supply_float: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (!pg_q && i_host_source_select[2]) |=> o_pin_oe[23:16] == 8'h00)
    else $error("Group I driven with invalid supply.");
  chk_dir_h_oe: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (pg_q && i_host_source_select[1]) |=> o_pin_oe[15:8] == $past(dir_h_q))
    else $error("Group H enable does not follow direction.");
  chk_mcu_select: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !i_host_source_select[0] |=> o_pin_oe[7:0] == $past(i_mcu_dir[7:0]))
    else $error("Controller drive not selected.");

  // The group G level trails its pin by exactly two edges, no more and no less.
  sequence s_g_level_lag;
    lvl_g == $past(i_pin[7:0], 2);
  endsequence

  // A pin change must show the old level for two edges, then the new one.
  chk_sync_depth: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $changed(i_pin[7:0]) |-> s_g_level_lag ##1 s_g_level_lag ##1 s_g_level_lag)
    else $error("Group G level not two flops behind pin.");

  // No access taken means no acknowledge on the next cycle.
  chk_ack_pulse: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !(rd_en || wr_en) |=> !o_ack)
    else $error("Acknowledge without a decoded access.");

  // Read data stands until the next decoded read.
  chk_rdata_hold: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !rd_en |=> $stable(o_rdata))
    else $error("Read data changed without a read.");

  // A write to the group I level register leaves every stored register alone.
  chk_ro_keep: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (wr_en && ofs == hgg_pkg::OFS_LVL_I) |=>
    $stable({dir_g_q, drv_g_q, dir_h_q, drv_h_q, dir_i_q, drv_i_q}))
    else $error("Write to group I level register changed storage.");

  // Group H level register returns the synchronised group H pins.
  chk_level_h_read: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (rd_en && ofs == hgg_pkg::OFS_LVL_H) |=> o_rdata == $past(lvl_h))
    else $error("Group H level read wrong.");

  // Group I drive value register reads back what it holds.
  chk_drv_i_read: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (rd_en && ofs == hgg_pkg::OFS_DRV_I) |=> o_rdata == $past(drv_i_q))
    else $error("Group I drive value read wrong.");

  // With pass-through on, group H host drive carries the group G levels.
  chk_pass_route: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (i_pass_through_en && pg_q && i_host_source_select[hgg_pkg::SEL_H]) |=>
    o_pin_out[15:8] == $past(lvl_g))
    else $error("Pass-through does not route group G levels.");

  // A host-selected group G floats while the supply is not valid.
  chk_float_g: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (!pg_q && i_host_source_select[hgg_pkg::SEL_G]) |=> o_pin_oe[7:0] == 8'h00)
    else $error("Group G driven with invalid supply.");

  // With the host selected and the supply valid, group I enables follow the group I direction register.
  chk_dir_i_oe: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (pg_q && i_host_source_select[hgg_pkg::SEL_I]) |=> o_pin_oe[23:16] == $past(dir_i_q))
    else $error("Group I enable does not follow direction.");

endmodule : hgg_regs

// [logic/hgg_pkg.sv]
// Purpose: Shared constants and carrier types for the host pin group registers.
// Assumes: Byte-wide host I/O accesses with a 16-bit I/O address.
// Notes: Offsets are relative to the relocatable block base.
package hgg_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [3:0] OFS_DIR_G = 4'h0;
  localparam logic [3:0] OFS_LVL_G = 4'h1;
  localparam logic [3:0] OFS_DRV_G = 4'h2;
  localparam logic [3:0] OFS_DIR_H = 4'h3;
  localparam logic [3:0] OFS_LVL_H = 4'h4;
  localparam logic [3:0] OFS_DRV_H = 4'h5;
  localparam logic [3:0] OFS_DIR_I = 4'h6;
  localparam logic [3:0] OFS_LVL_I = 4'h7;
  localparam logic [3:0] OFS_DRV_I = 4'h8;

  // ----------------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;
  localparam int SEL_G = 0;
  localparam int SEL_H = 1;
  localparam int SEL_I = 2;
  localparam int BASE_ALIGN_BITS = 4;

  // Host I/O request carried as one bundle.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } hgg_req_t;

  // Per-group pin drive result.
  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] dout;
  } hgg_pins_t;

endpackage : hgg_pkg

// [logic/hgg_group.sv]
// Purpose: One eight-pin group: host/controller source mux and pin sampler.
// Assumes: Pin inputs arrive asynchronously to i_mclk.
// Notes: Output enables are high while the pin is driven.
`timescale 1ns/10ps
module hgg_group (
  input wire logic i_mclk, // Bus clock.
  input wire logic i_reset_n, // Asynchronous reset, active low.
  input wire logic i_host_sel, // One: host registers drive the pins.
  input wire logic i_supply_ok, // Standby supply valid, synchronised.
  input wire logic [7:0] i_host_dir, // Host direction, one is output.
  input wire logic [7:0] i_host_val, // Host drive values.
  input wire logic [7:0] i_mcu_dir, // Controller direction.
  input wire logic [7:0] i_mcu_val, // Controller drive values.
  input wire logic [7:0] i_pin, // Raw pin levels.
  output hgg_pkg::hgg_pins_t o_pins, // Registered drive and enable.
  output logic [7:0] o_level // Synchronised pin levels.
);

  // ----------------------------------------------------------------------
  // Pin level synchroniser
  // ----------------------------------------------------------------------
  logic [7:0] meta_q;
  logic [7:0] level_q;

  // Two flops before any reader sees a pin level.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_q <= hgg_pkg::RST_REG;
      level_q <= hgg_pkg::RST_REG;
    end else begin
      meta_q <= i_pin;
      level_q <= meta_q;
    end
  end
  assign o_level = level_q;

  // ----------------------------------------------------------------------
  // Drive selection
  // ----------------------------------------------------------------------
  wire [7:0] host_oe = i_supply_ok ? i_host_dir : 8'h00;
  wire [7:0] sel_oe = i_host_sel ? host_oe : i_mcu_dir;
  wire [7:0] sel_val = i_host_sel ? i_host_val : i_mcu_val;
  hgg_pkg::hgg_pins_t pins_q;

  // Register the chosen drive so pin outputs come from flops.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pins_q <= '0;
    end else begin
      pins_q <= '{oe: sel_oe, dout: sel_val};
    end
  end
  assign o_pins = pins_q;

endmodule : hgg_group

// [tb/hgg_host_model.sv]
// Purpose: Host model that issues single-byte I/O cycles to the pin group registers.
// Assumes: A request is taken on the edge after it is driven and answered on that same edge.
// Notes: Released address and data lines show the inverse of their last value.
`timescale 1ns/10ps
module hgg_host_model (
  input wire logic i_mclk, // Bus clock.
  input wire logic i_ack, // Access complete pulse.
  input wire logic [7:0] i_rdata, // Read data.
  output hgg_pkg::hgg_req_t o_req // Request bundle.
);
  // ----------------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------------
  // The bus idles with both strobes low from time zero.
  initial o_req = '0;

  // One byte cycle: strobes stand one clock, the answer is read once it has settled.
  task automatic xfer(input logic wr, input logic rd, input logic [15:0] a,
                      input logic [7:0] d, output logic [7:0] q, output logic ack);
    @(posedge i_mclk);
    #1 o_req = '{rd: rd, wr: wr, addr: a, wdata: d};
    @(posedge i_mclk);
    #1 o_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    ack = i_ack;
    q = i_rdata;
  endtask : xfer
endmodule : hgg_host_model

// [tb/tb.sv]
// Purpose: Self-checking bench for the host pin group registers.
// Assumes: The host model performs every register access.
// Notes: Ordinary accesses come from a table; pin, decode and reset cases follow it.
`timescale 1ns/10ps
module tb;
  typedef struct packed {logic wr; logic [3:0] ofs; logic [7:0] wd; logic [7:0] ex;} hgg_row_t;
  logic [15:0] base = 16'h0a37; // Block base, moved once to test relocation.
  localparam logic [15:0] BA = 16'h0a30;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  hgg_pkg::hgg_req_t req;
  logic act = 1'b1, pte = 1'b0, sup = 1'b1;
  logic [2:0] sel = 3'h7;
  logic [23:0] mdir = 24'h0ff0f0, mval = 24'h123456, pin = 24'hc35aa5;
  logic [23:0] pout, poe;
  logic [7:0] rdata, q;
  logic ack, a;
  int miscompares = 0;
  int total_checks = 0;
  // Reset values, writes, read-only writes, read-backs, pin levels, reserved offset.
  hgg_row_t rows [24] = '{
    '{1'b0, 4'h0, 8'h00, 8'h00}, '{1'b0, 4'h2, 8'h00, 8'h00}, '{1'b0, 4'h3, 8'h00, 8'h00},
    '{1'b0, 4'h5, 8'h00, 8'h00}, '{1'b0, 4'h6, 8'h00, 8'h00}, '{1'b0, 4'h8, 8'h00, 8'h00},
    '{1'b1, 4'h0, 8'hff, 8'h00}, '{1'b1, 4'h2, 8'h3c, 8'h00}, '{1'b1, 4'h3, 8'h0f, 8'h00},
    '{1'b1, 4'h5, 8'h81, 8'h00}, '{1'b1, 4'h6, 8'hf0, 8'h00}, '{1'b1, 4'h8, 8'h96, 8'h00},
    '{1'b1, 4'h1, 8'hff, 8'h00}, '{1'b1, 4'h7, 8'hff, 8'h00}, '{1'b0, 4'h0, 8'h00, 8'hff},
    '{1'b0, 4'h2, 8'h00, 8'h3c}, '{1'b0, 4'h3, 8'h00, 8'h0f}, '{1'b0, 4'h5, 8'h00, 8'h81},
    '{1'b0, 4'h6, 8'h00, 8'hf0}, '{1'b0, 4'h8, 8'h00, 8'h96}, '{1'b0, 4'h1, 8'h00, 8'ha5},
    '{1'b0, 4'h4, 8'h00, 8'h5a}, '{1'b0, 4'h7, 8'h00, 8'hc3}, '{1'b0, 4'h9, 8'h00, 8'h00}};

  // ----------------------------------------------------------------------
  // Clock, design and host
  // ----------------------------------------------------------------------
  // The bus clock runs at 25 MHz.
  always #20 i_mclk = ~i_mclk;

  hgg_regs i_dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_req(req), .i_activate(act),
    .i_base(base), .i_host_source_select(sel), .i_pass_through_en(pte),
    .i_standby_supply_valid(sup), .i_mcu_dir(mdir), .i_mcu_val(mval), .i_pin(pin),
    .o_pin_out(pout), .o_pin_oe(poe), .o_rdata(rdata), .o_ack(ack));
  hgg_host_model i_host (.i_mclk(i_mclk), .i_ack(ack), .i_rdata(rdata), .o_req(req));

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Lets n rising edges pass and steps just past the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : tick

  // Prints the verdict and ends the run.
  task automatic close_out;
    if (miscompares == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  // Cuts a hang short after far more time than the sequence needs.
  initial begin
    #(40 * 3000);
    miscompares++;
    close_out();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  // Table rows first, then the hand-written cases.
  initial begin
    tick(8);
    i_reset_n = 1'b1;
    foreach (rows[k]) begin
      i_host.xfer(rows[k].wr, !rows[k].wr, BA + 16'(rows[k].ofs), rows[k].wd, q, a);
      chk("ack", 24'h000001, 24'(a));
      if (!rows[k].wr) chk("rdata", 24'(rows[k].ex), 24'(q));
    end
    tick(2);
    chk("pin_oe", 24'hf00fff, poe);
    chk("pin_out", 24'h90013c, pout & poe);
    pte = 1'b1;
    tick(4);
    chk("pass_out", 24'h90053c, pout & poe);
    pte = 1'b0;
    sup = 1'b0;
    tick(4);
    chk("float_oe", 24'h000000, poe);
    sel = 3'h0;
    tick(3);
    chk("mcu_oe", mdir, poe);
    chk("mcu_out", mval & mdir, pout & poe);
    i_host.xfer(1'b0, 1'b1, BA, 8'h00, q, a);
    chk("sel_rd", 24'h0000ff, 24'(q));
    sup = 1'b1;
    sel = 3'h7;
    pin = 24'hc35a0f;
    i_host.xfer(1'b0, 1'b1, BA + 16'h0001, 8'h00, q, a);
    chk("sync_old", 24'h0000a5, 24'(q));
    i_host.xfer(1'b0, 1'b1, BA + 16'h0001, 8'h00, q, a);
    chk("sync_rd", 24'h00000f, 24'(q));
    act = 1'b0;
    i_host.xfer(1'b0, 1'b1, BA, 8'h00, q, a);
    chk("off_ack", 24'h000000, 24'(a));
    act = 1'b1;
    i_host.xfer(1'b1, 1'b0, 16'h0b32, 8'h00, q, a);
    chk("far_ack", 24'h000000, 24'(a));
    i_host.xfer(1'b0, 1'b1, BA + 16'h0002, 8'h00, q, a);
    chk("far_keep", 24'h00003c, 24'(q));
    base = 16'h0b3f;
    i_host.xfer(1'b0, 1'b1, 16'h0b32, 8'h00, q, a);
    chk("moved_rd", 24'h00003c, 24'(q));
    i_host.xfer(1'b0, 1'b1, BA, 8'h00, q, a);
    chk("old_ack", 24'h000000, 24'(a));
    base = 16'h0a37;
    i_host.xfer(1'b1, 1'b1, BA + 16'h0005, 8'h7e, q, a);
    chk("rw_old", 24'h000081, 24'(q));
    i_host.xfer(1'b0, 1'b1, BA + 16'h0005, 8'h00, q, a);
    chk("rw_new", 24'h00007e, 24'(q));
    i_reset_n = 1'b0;
    tick(1);
    i_reset_n = 1'b1;
    i_host.xfer(1'b0, 1'b1, BA + 16'h0008, 8'h00, q, a);
    chk("rst_drv", 24'h000000, 24'(q));
    close_out();
  end
endmodule : tb
